// ===== hdl/stg_timer_group.sv
// Timer group: compatible 16-bit timer, two 16-bit system timers, 24-bit timer
`timescale 1ns/1ps
`default_nettype none
module stg_timer_group (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Register port
    input  wire stg_pkg::stg_bus_req_t bus,
    output var  logic [7:0]            rd_data,
    // Pins
    input  wire logic                  ext_trigger_pin,
    input  wire logic                  ext_count_pin,
    input  wire logic [3:0]            t5_src_clk,
    // First timer overflow from the legacy timer block
    input  wire logic                  t1_ovf_tick,
    // Serial port bit clocks
    output logic                       uart_rx_tick,
    output logic                       uart_tx_tick,
    // Interrupt requests
    output logic                       t2_irq,
    output logic                       t3_irq,
    output logic                       t4_irq,
    output logic                       t5_irq
);
    import stg_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [5:0] pin_s3;
    logic [5:0] pin_fall;
    logic [5:0] pin_rise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_s3 <= '1;
        end else begin
            pin_s1 <= {t5_src_clk, ext_count_pin, ext_trigger_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Edges are taken between stages two and three only
    assign pin_fall = pin_s3 & ~pin_s2;
    assign pin_rise = pin_s2 & ~pin_s3;

    // ****************************************
    // Bus decode
    // ****************************************
    logic wr_t2_ctrl;
    logic wr_t34_ctrl;
    logic wr_t5_ctrl;

    assign wr_t2_ctrl  = bus.wr && bus.addr == STG_ADDR_T2_CTRL;
    assign wr_t34_ctrl = bus.wr && bus.addr == STG_ADDR_T34_CTRL;
    assign wr_t5_ctrl  = bus.wr && bus.addr == STG_ADDR_T5_CTRL;

    // ****************************************
    // Compatible timer: mode decode
    // ****************************************
    logic [7:0]   t2_ctrl;
    logic [15:0]  t2_count;
    logic [15:0]  t2_rld;
    stg_t2_mode_t t2_mode;
    logic         t2_baud;
    logic         t2_tick;
    logic         t2_ovf;
    logic         t2_ext;

    assign t2_baud = t2_ctrl[STG_T2_RXSEL] | t2_ctrl[STG_T2_TXSEL];

    always_comb begin
        if (!t2_ctrl[STG_T2_RUN]) begin
            t2_mode = STG_T2_STOP;
        end else if (t2_baud) begin
            t2_mode = STG_T2_BAUD;
        end else if (t2_ctrl[STG_T2_CPRL]) begin
            t2_mode = STG_T2_CAPT;
        end else begin
            t2_mode = STG_T2_AUTO;
        end
    end

    // Count pin falling edges in counter mode, every clock in timer mode
    assign t2_tick = t2_ctrl[STG_T2_CNTS] ? pin_fall[STG_PIN_CNT] : 1'b1;
    assign t2_ovf  = t2_mode != STG_T2_STOP && t2_tick && (&t2_count);
    assign t2_ext  = t2_mode != STG_T2_STOP && t2_ctrl[STG_T2_EXEN]
                     && pin_fall[STG_PIN_TRIG];

    // ****************************************
    // Compatible timer: counter and reload/capture
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t2_count <= STG_RST_WORD;
        end else if (bus.wr && bus.addr == STG_ADDR_T2_LOW) begin
            t2_count[7:0] <= bus.wdata;
        end else if (bus.wr && bus.addr == STG_ADDR_T2_HIGH) begin
            t2_count[15:8] <= bus.wdata;
        end else if (t2_ovf && t2_mode != STG_T2_CAPT) begin
            t2_count <= t2_rld;
        end else if (t2_ext && t2_mode == STG_T2_AUTO) begin
            t2_count <= t2_rld;
        end else if (t2_ovf) begin
            t2_count <= STG_RST_WORD;
        end else if (t2_mode != STG_T2_STOP && t2_tick) begin
            t2_count <= t2_count + 16'h0001;
        end
    end

    // A capture in the same cycle as a software write wins, so no event is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t2_rld <= STG_RST_WORD;
        end else if (t2_ext && t2_mode == STG_T2_CAPT) begin
            t2_rld <= t2_count;
        end else if (bus.wr && bus.addr == STG_ADDR_RLD_LOW) begin
            t2_rld[7:0] <= bus.wdata;
        end else if (bus.wr && bus.addr == STG_ADDR_RLD_HIGH) begin
            t2_rld[15:8] <= bus.wdata;
        end
    end

    // ****************************************
    // Compatible timer: control and flags
    // ****************************************
    logic [7:0] next_t2_ctrl;

    always_comb begin
        next_t2_ctrl = wr_t2_ctrl ? bus.wdata : t2_ctrl;
        // The overflow flag stays quiet while the timer paces the serial port
        if (t2_ovf && t2_mode != STG_T2_BAUD) begin
            next_t2_ctrl[STG_T2_FLAG] = 1'b1;
        end
        if (t2_ext) begin
            next_t2_ctrl[STG_T2_EXF] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t2_ctrl <= STG_RST_BYTE;
        end else begin
            t2_ctrl <= next_t2_ctrl;
        end
    end

    assign t2_irq = t2_ctrl[STG_T2_FLAG] | t2_ctrl[STG_T2_EXF];

    // Serial bit clocks: this timer's overflow when selected, else the first timer's
    assign uart_rx_tick = t2_ctrl[STG_T2_RXSEL] ? (t2_ovf && t2_mode == STG_T2_BAUD)
                                               : t1_ovf_tick;
    assign uart_tx_tick = t2_ctrl[STG_T2_TXSEL] ? (t2_ovf && t2_mode == STG_T2_BAUD)
                                               : t1_ovf_tick;

    // ****************************************
    // Third and fourth timers
    // ****************************************
    logic [7:0]  t34_ctrl;
    logic [7:0]  next_t34_ctrl;
    logic [15:0] t34_count [2];
    logic [1:0]  t34_ovf;
    logic [1:0]  t34_irq;

    for (genvar i = 0; i < 2; i++) begin : g_t34
        localparam int           BASE = i * 4;
        localparam logic [7:0] A_LOW  = (i == 0) ? STG_ADDR_T3_LOW : STG_ADDR_T4_LOW;
        localparam logic [7:0] A_HIGH = (i == 0) ? STG_ADDR_T3_HIGH : STG_ADDR_T4_HIGH;
        logic wr_hit;

        assign wr_hit = bus.wr && (bus.addr == A_LOW || bus.addr == A_HIGH);

        stg_timer16 #(
            .WIDTH       (16)
        ) u_tmr (
            .clk         (clk),
            .rst_n       (rst_n),
            .tick        (1'b1),
            .run         (t34_ctrl[BASE + STG_NIB_RUN]),
            .reload_mode (t34_ctrl[BASE + STG_NIB_MODE]),
            .wr_en       (wr_hit),
            .wr_byte     ({1'b0, bus.addr == A_HIGH}),
            .wr_data     (bus.wdata),
            .count       (t34_count[i]),
            .ovf         (t34_ovf[i])
        );

        assign t34_irq[i] = t34_ctrl[BASE + STG_NIB_FLAG]
                            & t34_ctrl[BASE + STG_NIB_IEN];

        chk_t34_flag_set: assert property (t34_ovf[i] |=> t34_ctrl[BASE + STG_NIB_FLAG])
            else $error("overflow did not set flag");
        chk_t34_halt: assert property (!t34_ctrl[BASE + STG_NIB_RUN] && !wr_hit
                                       |=> $stable(t34_count[i]))
            else $error("halted timer moved");
        chk_t34_wrap: assert property (t34_ovf[i] && !t34_ctrl[BASE + STG_NIB_MODE]
                                       |=> t34_count[i] == 16'h0000)
            else $error("free-run timer did not wrap to zero");
        chk_t34_irq_gate: assert property (t34_ovf[i] && !wr_t34_ctrl
                                           && t34_ctrl[BASE + STG_NIB_IEN]
                                           |=> t34_irq[i])
            else $error("enabled overflow raised no request");
        chk_t34_live_write: assert property (wr_hit && !t34_ctrl[BASE + STG_NIB_MODE]
                                             && bus.addr == A_LOW
                                             |=> t34_count[i][7:0] == $past(bus.wdata))
            else $error("free-run write did not reach counter");
    end

    // Flags are set by overflow even while software writes the byte
    always_comb begin
        next_t34_ctrl = wr_t34_ctrl ? bus.wdata : t34_ctrl;
        for (int i = 0; i < 2; i++) begin
            if (t34_ovf[i]) begin
                next_t34_ctrl[i*4 + STG_NIB_FLAG] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t34_ctrl <= STG_RST_BYTE;
        end else begin
            t34_ctrl <= next_t34_ctrl;
        end
    end

    assign t3_irq = t34_irq[0];
    assign t4_irq = t34_irq[1];

    // ****************************************
    // Fifth timer
    // ****************************************
    logic [7:0]  t5_ctrl;
    logic [7:0]  next_t5_ctrl;
    logic [23:0] t5_count;
    logic [7:0]  t5_off;
    logic        t5_tick;
    logic        t5_ovf;
    logic        t5_wr;

    // The source is sampled by the system clock, so it must run slower than half of it
    assign t5_tick = pin_rise[STG_PIN_SRC + int'(t5_ctrl[STG_T5_SELHI:STG_T5_SELLO])];
    assign t5_off  = bus.addr - STG_ADDR_T5_CNT0;
    assign t5_wr   = bus.wr && bus.addr >= STG_ADDR_T5_CNT0 && bus.addr <= STG_ADDR_T5_CNT2;

    stg_timer16 #(
        .WIDTH       (24)
    ) u_t5 (
        .clk         (clk),
        .rst_n       (rst_n),
        .tick        (t5_tick),
        .run         (t5_ctrl[STG_T5_RUN]),
        .reload_mode (t5_ctrl[STG_T5_MODE]),
        .wr_en       (t5_wr),
        .wr_byte     (t5_off[1:0]),
        .wr_data     (bus.wdata),
        .count       (t5_count),
        .ovf         (t5_ovf)
    );

    always_comb begin
        next_t5_ctrl = wr_t5_ctrl ? (bus.wdata & STG_T5_WMASK) : t5_ctrl;
        if (t5_ovf) begin
            next_t5_ctrl[STG_T5_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t5_ctrl <= STG_RST_BYTE;
        end else begin
            t5_ctrl <= next_t5_ctrl;
        end
    end

    assign t5_irq = t5_ctrl[STG_T5_FLAG] & t5_ctrl[STG_T5_IEN];

    // ****************************************
    // Read port
    // ****************************************
    // Reads return the live count; software must read high byte first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= STG_RST_BYTE;
        end else if (!bus.rd) begin
            rd_data <= STG_RST_BYTE;
        end else begin
            unique case (bus.addr)
                STG_ADDR_T3_LOW:   rd_data <= t34_count[0][7:0];
                STG_ADDR_T3_HIGH:  rd_data <= t34_count[0][15:8];
                STG_ADDR_T4_LOW:   rd_data <= t34_count[1][7:0];
                STG_ADDR_T4_HIGH:  rd_data <= t34_count[1][15:8];
                STG_ADDR_T34_CTRL: rd_data <= t34_ctrl;
                STG_ADDR_T2_CTRL:  rd_data <= t2_ctrl;
                STG_ADDR_T2_LOW:   rd_data <= t2_count[7:0];
                STG_ADDR_T2_HIGH:  rd_data <= t2_count[15:8];
                STG_ADDR_RLD_LOW:  rd_data <= t2_rld[7:0];
                STG_ADDR_RLD_HIGH: rd_data <= t2_rld[15:8];
                STG_ADDR_T5_CTRL:  rd_data <= t5_ctrl;
                STG_ADDR_T5_CNT0:  rd_data <= t5_count[7:0];
                STG_ADDR_T5_CNT1:  rd_data <= t5_count[15:8];
                STG_ADDR_T5_CNT2:  rd_data <= t5_count[23:16];
                default:           rd_data <= STG_RST_BYTE;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************

    logic t2_cnt_wr;
    assign t2_cnt_wr = bus.wr && (bus.addr == STG_ADDR_T2_LOW || bus.addr == STG_ADDR_T2_HIGH);

    chk_t2_auto_reload: assert property (t2_mode == STG_T2_AUTO && t2_ovf && !t2_cnt_wr
                                         && !wr_t2_ctrl
                                         |=> t2_count == $past(t2_rld)
                                         && t2_ctrl[STG_T2_FLAG])
        else $error("auto-reload overflow misbehaved");
    chk_t2_ext_reload: assert property (t2_mode == STG_T2_AUTO && t2_ext && !t2_cnt_wr
                                        |=> t2_count == $past(t2_rld))
        else $error("trigger fall did not reload");
    chk_t2_capture: assert property (t2_mode == STG_T2_CAPT && t2_ext
                                     |=> t2_rld == $past(t2_count))
        else $error("trigger fall did not capture");
    chk_t2_baud_reload: assert property (t2_mode == STG_T2_BAUD && t2_ovf && !t2_cnt_wr
                                         |=> t2_count == $past(t2_rld))
        else $error("baud overflow did not reload");
    chk_t2_stopped: assert property (t2_mode == STG_T2_STOP && !t2_cnt_wr
                                     |=> $stable(t2_count))
        else $error("stopped timer moved");
    chk_baud_route: assert property (t2_mode == STG_T2_BAUD && t2_ovf
                                     && t2_ctrl[STG_T2_TXSEL] |-> uart_tx_tick)
        else $error("baud overflow missing on transmit clock");

    cov_capture:  cover property (t2_mode == STG_T2_CAPT && t2_ext);
    cov_baud:     cover property (t2_mode == STG_T2_BAUD && t2_ovf);
    cov_t34_rld:  cover property (t34_ovf[0] && t34_ctrl[STG_NIB_MODE]);
    cov_t5_ovf:   cover property (t5_ovf);
endmodule // stg_timer_group
`default_nettype wire

// ===== hdl/stg_pkg.sv
// Package: register map, field positions, reset values and types of the timer group
package stg_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] STG_ADDR_T4_LOW   = 8'hAC;
    localparam logic [7:0] STG_ADDR_T4_HIGH  = 8'hAD;
    localparam logic [7:0] STG_ADDR_T3_LOW   = 8'hAE;
    localparam logic [7:0] STG_ADDR_T3_HIGH  = 8'hAF;
    localparam logic [7:0] STG_ADDR_T5_CTRL  = 8'hB0;
    localparam logic [7:0] STG_ADDR_T5_CNT0  = 8'hB1;
    localparam logic [7:0] STG_ADDR_T5_CNT1  = 8'hB2;
    localparam logic [7:0] STG_ADDR_T5_CNT2  = 8'hB3;
    localparam logic [7:0] STG_ADDR_T2_CTRL  = 8'hC8;
    localparam logic [7:0] STG_ADDR_RLD_LOW  = 8'hCA;
    localparam logic [7:0] STG_ADDR_RLD_HIGH = 8'hCB;
    localparam logic [7:0] STG_ADDR_T2_LOW   = 8'hCC;
    localparam logic [7:0] STG_ADDR_T2_HIGH  = 8'hCD;
    localparam logic [7:0] STG_ADDR_T34_CTRL = 8'hCF;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  STG_RST_BYTE = 8'h00;
    localparam logic [15:0] STG_RST_WORD = 16'h0000;

    // ****************************************
    // Field positions
    // ****************************************
    // Compatible timer control byte
    localparam int STG_T2_FLAG  = 7;
    localparam int STG_T2_EXF   = 6;
    localparam int STG_T2_RXSEL = 5;
    localparam int STG_T2_TXSEL = 4;
    localparam int STG_T2_EXEN  = 3;
    localparam int STG_T2_RUN   = 2;
    localparam int STG_T2_CNTS  = 1;
    localparam int STG_T2_CPRL  = 0;
    // Dual timer nibble: timer3 at base 0, timer4 at base 4
    localparam int STG_NIB_FLAG = 3;
    localparam int STG_NIB_MODE = 2;
    localparam int STG_NIB_RUN  = 1;
    localparam int STG_NIB_IEN  = 0;
    // Timer5 control byte; bits 2..1 reserved
    localparam int STG_T5_FLAG  = 7;
    localparam int STG_T5_SELHI = 6;
    localparam int STG_T5_SELLO = 5;
    localparam int STG_T5_MODE  = 4;
    localparam int STG_T5_RUN   = 3;
    localparam int STG_T5_IEN   = 0;
    localparam logic [7:0] STG_T5_WMASK = 8'hF9;
    // Pin synchroniser lanes
    localparam int STG_PIN_TRIG = 0;
    localparam int STG_PIN_CNT  = 1;
    localparam int STG_PIN_SRC  = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } stg_bus_req_t;

    typedef enum logic [1:0] {
        STG_T2_STOP = 2'b00,
        STG_T2_AUTO = 2'b01,
        STG_T2_CAPT = 2'b10,
        STG_T2_BAUD = 2'b11
    } stg_t2_mode_t;
endpackage

// ===== hdl/stg_timer16.sv
// Reload / free-run counter with byte-wise software access
`timescale 1ns/1ps
`default_nettype none
module stg_timer16 #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             tick,
    input  wire logic             run,
    input  wire logic             reload_mode,
    // Byte write
    input  wire logic             wr_en,
    input  wire logic [1:0]       wr_byte,
    input  wire logic [7:0]       wr_data,
    // Status
    output var  logic [WIDTH-1:0] count,
    output logic                  ovf
);
    import stg_pkg::*;

    localparam int NB = WIDTH / 8;

    logic [7:0]       reload_b [NB];
    logic [WIDTH-1:0] reload;
    logic [WIDTH-1:0] next_count;
    logic             wr_live;

    // Free-run writes go straight to the counter, reload-mode writes to the shadow
    assign wr_live = wr_en && !reload_mode;
    assign ovf     = run && tick && (&count) && !wr_live;

    // ****************************************
    // Reload value, one byte per entry
    // ****************************************
    for (genvar b = 0; b < NB; b++) begin : g_rld
        assign reload[b*8 +: 8] = reload_b[b];
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                reload_b[b] <= STG_RST_BYTE;
            end else if (wr_en && reload_mode && wr_byte == 2'(b)) begin
                reload_b[b] <= wr_data;
            end
        end
    end

    // ****************************************
    // Counter
    // ****************************************
    always_comb begin
        next_count = count;
        if (wr_live) begin
            next_count[int'(wr_byte)*8 +: 8] = wr_data;
        end else if (ovf) begin
            next_count = reload_mode ? reload : '0;
        end else if (run && tick) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule // stg_timer16
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the timer group register and timer behaviour
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import stg_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic         clk;
    logic         rst_n;
    stg_bus_req_t bus;
    logic [7:0]   rd_data;
    logic         trig;
    logic         cnt_pin;
    logic [3:0]   src;
    logic         t1;
    logic         rxt;
    logic         txt;
    logic         irq2;
    logic         irq3;
    logic         irq4;
    logic         irq5;
    int           fails;
    int           checked;
    int           n;

    stg_timer_group i_stg_timer_group (.clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
        .ext_trigger_pin(trig), .ext_count_pin(cnt_pin), .t5_src_clk(src), .t1_ovf_tick(t1),
        .uart_rx_tick(rxt), .uart_tx_tick(txt), .t2_irq(irq2), .t3_irq(irq3), .t4_irq(irq4),
        .t5_irq(irq5));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus <= '{a, d, 1'b0, 1'b0};
    endtask

    // Read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b0};
        #1 chk(rd_data, exp);
    endtask

    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst_n = 1'b0; bus = '0; trig = 1'b1; cnt_pin = 1'b1; src = 4'h0; t1 = 1'b0;
        fails = 0; checked = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rc(STG_ADDR_T4_LOW + 8'(i), 8'h00);
        end
        rc(STG_ADDR_T34_CTRL, 8'h00);
        rc(8'h10, 8'h00);
        @(posedge clk) t1 <= 1'b1;
        #1 chk({6'h00, rxt, txt}, 8'h03);
        @(posedge clk) t1 <= 1'b0;
        $display("reset and select test done");
        wr(STG_ADDR_T3_HIGH, 8'hFF); wr(STG_ADDR_T3_LOW, 8'hFE);
        rc(STG_ADDR_T3_HIGH, 8'hFF);
        rc(STG_ADDR_T3_LOW, 8'hFE);
        wr(STG_ADDR_T34_CTRL, 8'h03);
        repeat (6) @(posedge clk);
        rc(STG_ADDR_T34_CTRL, 8'h0B);
        chk({7'h00, irq3}, 8'h01);
        rc(STG_ADDR_T3_HIGH, 8'h00);
        wr(STG_ADDR_T34_CTRL, 8'h01);
        #1 chk({7'h00, irq3}, 8'h00);
        rc(STG_ADDR_T3_LOW, 8'h0A);
        rc(STG_ADDR_T3_LOW, 8'h0A);
        $display("timer3 test done");
        wr(STG_ADDR_T4_HIGH, 8'hFF); wr(STG_ADDR_T4_LOW, 8'hF0);
        wr(STG_ADDR_T34_CTRL, 8'h40);
        wr(STG_ADDR_T4_LOW, 8'h34); wr(STG_ADDR_T4_HIGH, 8'h12);
        rc(STG_ADDR_T4_HIGH, 8'hFF);
        rc(STG_ADDR_T4_LOW, 8'hF0);
        wr(STG_ADDR_T34_CTRL, 8'h60);
        repeat (20) @(posedge clk);
        rc(STG_ADDR_T34_CTRL, 8'hE0);
        chk({7'h00, irq4}, 8'h00);
        rc(STG_ADDR_T4_HIGH, 8'h12);
        wr(STG_ADDR_T34_CTRL, 8'hF0);
        #1 chk({7'h00, irq4}, 8'h01);
        wr(STG_ADDR_T34_CTRL, 8'h00);
        $display("timer4 test done");
        wr(STG_ADDR_RLD_LOW, 8'h00); wr(STG_ADDR_RLD_HIGH, 8'h77);
        wr(STG_ADDR_T2_HIGH, 8'hFF); wr(STG_ADDR_T2_LOW, 8'hFE);
        wr(STG_ADDR_T2_CTRL, 8'h04);
        repeat (8) @(posedge clk);
        rc(STG_ADDR_T2_CTRL, 8'h84);
        chk({7'h00, irq2}, 8'h01);
        rc(STG_ADDR_T2_HIGH, 8'h77);
        wr(STG_ADDR_T2_CTRL, 8'h00);
        wr(STG_ADDR_T2_HIGH, 8'h5A); wr(STG_ADDR_T2_LOW, 8'h00);
        wr(STG_ADDR_T2_CTRL, 8'h0D);
        @(posedge clk) trig <= 1'b0;
        repeat (8) @(posedge clk);
        trig <= 1'b1;
        rc(STG_ADDR_T2_CTRL, 8'h4D);
        rc(STG_ADDR_RLD_HIGH, 8'h5A);
        wr(STG_ADDR_T2_CTRL, 8'h0C);
        wr(STG_ADDR_T2_HIGH, 8'h10);
        @(posedge clk) trig <= 1'b0;
        repeat (8) @(posedge clk);
        trig <= 1'b1;
        rc(STG_ADDR_T2_HIGH, 8'h5A);
        wr(STG_ADDR_T2_CTRL, 8'h00);
        rc(STG_ADDR_T2_HIGH, 8'h5A);
        wr(STG_ADDR_RLD_LOW, 8'hF0); wr(STG_ADDR_RLD_HIGH, 8'hFF);
        wr(STG_ADDR_T2_HIGH, 8'hFF); wr(STG_ADDR_T2_LOW, 8'hF0);
        wr(STG_ADDR_T2_CTRL, 8'h35);
        repeat (4) @(posedge clk);
        n = 0;
        // Reload every 16 counts, so any 64-cycle window holds exactly four ticks on each bit clock, eight in all
        repeat (64) begin
            @(posedge clk);
            #1 n = n + int'(rxt) + int'(txt);
        end
        chk(8'(n), 8'h08);
        rc(STG_ADDR_T2_CTRL, 8'h35);
        // Counter mode: only count-pin falls advance the timer
        wr(STG_ADDR_T2_CTRL, 8'h00);
        wr(STG_ADDR_T2_HIGH, 8'h00);
        wr(STG_ADDR_T2_LOW, 8'h00);
        wr(STG_ADDR_T2_CTRL, 8'h06);
        repeat (3) begin
            repeat (3) @(posedge clk);
            cnt_pin <= 1'b0;
            repeat (3) @(posedge clk);
            cnt_pin <= 1'b1;
        end
        repeat (4) @(posedge clk);
        rc(STG_ADDR_T2_LOW, 8'h03);
        wr(STG_ADDR_T2_CTRL, 8'h00);
        $display("compat timer test done");
        wr(STG_ADDR_T5_CNT2, 8'hFF);
        wr(STG_ADDR_T5_CNT1, 8'hFF);
        wr(STG_ADDR_T5_CNT0, 8'hFD);
        wr(STG_ADDR_T5_CTRL, 8'h49);
        // Lane 0 toggles twice as fast as the selected lane 2 and must not count
        for (int k = 0; k < 16; k++) begin
            repeat (3) @(posedge clk);
            src <= {1'b0, k[1], 1'b0, k[0]};
        end
        repeat (4) @(posedge clk);
        rc(STG_ADDR_T5_CTRL, 8'hC9);
        chk({7'h00, irq5}, 8'h01);
        rc(STG_ADDR_T5_CNT2, 8'h00);
        rc(STG_ADDR_T5_CNT0, 8'h01);
        $display("timer5 test done");
        test_done;
    end

    initial begin
        #2500000;
        fails++;
        test_done;
    end
endmodule // tb_top
`default_nettype wire
